//--- rtl/plsr_regs.sv
// Purpose: per-port link and slot capability, control and status registers
// Assumes: one config write/read port, core clock 40 MHz, async low reset
// Notes:   training, slot status sources and loader sit outside this block
//
// Summary of operation
// - max link speed bits 3:0, read only, resets 5 Gb/s, loadable
// - max link width bits 9:4, read only, resets to one lane
// - fast-standby exit latency bits 14:12 resets 011b, loadable
// - deep low-power exit latency bits 17:15 resets 000b, loadable
// - power management support bits 11:10 read only, resets zero, loadable
// - link-active reporting bit 20 zero upstream, one hot-plug downstream
// - bandwidth notify capable bit 21 zero upstream, one downstream
// - port number bits 31:24 resets to own port index, loadable
// - power control bits 1:0 choose allowed low-power entries, reset 00b
// - link disable bit 4 zero upstream, disables downstream link
// - retrain bit starts retraining downstream, always reads zero
// - common clock configuration bit 6 writable, resets zero
// - extended synch sends 4096 training sets on low-power exit
// - current speed bits 19:16 report negotiated rate, reset 0010b
// - training error bit 26 set on failure, cleared on good training
// - link training bit 27 reads one while training runs
// - slot clock bit 28 resets to zero, then takes the slot clock strap level
// - link active bit 29 is one while data link layer is active
// - downstream slot power limit value/scale writable, write sends message
// - indicator controls 01 on 10 blink 11 off, reset 11b, a write sends one message, the attention kind if both are written
// - hot-plug interrupt needs master enable bit 5 and event enable
// - power controller bit 10: zero power on, one power off
// - link-active change sets slot status bit 24
`timescale 1ns/10ps
`default_nettype none
`include "plsr_defs.svh"
module plsr_regs #(
	parameter logic [7:0] PORT_INDEX = 8'h00,
	parameter bit         IS_UPSTREAM = 1'b1
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// configuration access
	input  wire logic              cfg_wr,
	input  wire logic              cfg_rd,
	input  wire logic [7:0]        cfg_addr,
	input  wire logic [3:0]        cfg_be,
	input  wire logic [31:0]       cfg_wdata,
	output var  logic [31:0]       cfg_rdata,
	// management bus / autoload override of capability defaults
	input  wire logic              ld_valid,
	input  wire logic [3:0]        ld_max_speed,
	input  wire logic [1:0]        ld_active_state_power_mgmt,
	input  wire logic [2:0]        ld_l0s_lat,
	input  wire logic [2:0]        ld_l1_lat,
	input  wire logic [7:0]        ld_port_num,
	// strap pins
	input  wire logic              slot_clock_strap,
	input  wire logic              hot_plug_strap,
	// physical and link layer status
	input  wire logic              phy_training,
	input  wire logic              phy_train_fail,
	input  wire logic              phy_in_l0,
	input  wire logic              phy_speed_5g,
	input  wire logic              dl_active,
	input  wire logic              lp_exit,
	// hot-plug event status from the slot logic
	input  wire logic              hp_button,
	input  wire logic              hp_pwr_fault,
	input  wire logic              hp_presence,
	input  wire logic              hp_cmd_done,
	// link controls
	output var  logic [1:0]        active_state_power_mgmt,
	output var  logic              link_disable,
	output logic                   retrain_pulse,
	output var  logic              common_clock,
	output var  logic [12:0]       fts_count,
	output logic                   fts_send,
	// slot controls and messages
	output var  logic [1:0]        attn_ind,
	output var  logic [1:0]        pwr_ind,
	output var  logic              slot_power_off,
	output var  logic [7:0]        slot_pwr_value,
	output var  logic [1:0]        slot_pwr_scale,
	output plsr_pkg::plsr_msg_t    msg_kind,
	output logic                   msg_valid,
	output logic                   hp_irq,
	output var  logic              dl_changed
);
	//------------------------------------------------------------
	// strap synchronisers
	//------------------------------------------------------------
	logic [1:0] strap_s;
	logic       strap_done_r;
	logic       slot_clk_r;
	logic       hp_cap_r;

	plsr_sync #(.W(2)) u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.d     ({slot_clock_strap, hot_plug_strap}),
		.q     (strap_s)
	);

	// captured once after release so straps can settle through the syncer
	logic [1:0] strap_wait_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_wait_r <= 2'h0;
			strap_done_r <= 1'b0;
			slot_clk_r   <= 1'b0;
			hp_cap_r     <= 1'b0;
		end else if (!strap_done_r) begin
			strap_wait_r <= strap_wait_r + 2'h1;
			if (strap_wait_r == 2'h3) begin
				strap_done_r <= 1'b1;
				slot_clk_r   <= strap_s[1];
				hp_cap_r     <= strap_s[0] & ~IS_UPSTREAM;
			end
		end
	end

	//------------------------------------------------------------
	// access decode
	//------------------------------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction : hit

	logic wr_lcap, wr_lctl, wr_scap, wr_sctl;
	assign wr_lcap = cfg_wr & hit(cfg_addr, `PLSR_OFS_LINK_CAP);
	assign wr_lctl = cfg_wr & hit(cfg_addr, `PLSR_OFS_LINK_CTL);
	assign wr_scap = cfg_wr & hit(cfg_addr, `PLSR_OFS_SLOT_CAP);
	assign wr_sctl = cfg_wr & hit(cfg_addr, `PLSR_OFS_SLOT_CTL);

	//------------------------------------------------------------
	// link capabilities (loader only; config writes ignored)
	//------------------------------------------------------------
	logic [3:0] max_speed_r;
	logic [1:0] active_state_power_mgmt_sup_r;
	logic [2:0] l0s_lat_r;
	logic [2:0] l1_lat_r;
	logic [7:0] port_num_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			max_speed_r <= `PLSR_RST_MAX_SPEED;
			active_state_power_mgmt_sup_r  <= `PLSR_RST_ACTIVE_STATE_POWER_MGMT_SUP;
			l0s_lat_r   <= `PLSR_RST_L0S_LAT;
			l1_lat_r    <= `PLSR_RST_L1_LAT;
			port_num_r  <= PORT_INDEX;
		end else if (ld_valid) begin
			max_speed_r <= ld_max_speed;
			active_state_power_mgmt_sup_r  <= ld_active_state_power_mgmt;
			l0s_lat_r   <= ld_l0s_lat;
			l1_lat_r    <= ld_l1_lat;
			port_num_r  <= ld_port_num;
		end
	end

	logic [31:0] lcap_word;
	always_comb begin
		lcap_word        = 32'h0000_0000;
		lcap_word[3:0]   = max_speed_r;
		lcap_word[9:4]   = `PLSR_RST_MAX_WIDTH;
		lcap_word[11:10] = active_state_power_mgmt_sup_r;
		lcap_word[14:12] = l0s_lat_r;
		lcap_word[17:15] = l1_lat_r;
		lcap_word[20]    = hp_cap_r;
		lcap_word[21]    = ~IS_UPSTREAM;
		lcap_word[31:24] = port_num_r;
	end

	//------------------------------------------------------------
	// link control
	//------------------------------------------------------------
	logic ext_sync_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			active_state_power_mgmt <= 2'h0;
			link_disable            <= 1'b0;
			common_clock            <= 1'b0;
			ext_sync_r              <= 1'b0;
		end else if (wr_lctl && cfg_be[0]) begin
			// 10b is not a defined selection; it is dropped to disabled
			active_state_power_mgmt <= (cfg_wdata[1:0] == 2'h2) ?
				2'h0 : cfg_wdata[1:0];
			link_disable <= cfg_wdata[4] & ~IS_UPSTREAM;
			common_clock <= cfg_wdata[6];
			ext_sync_r   <= cfg_wdata[7];
		end
	end

	// retrain has no storage: it only fires a pulse and reads back zero
	assign retrain_pulse = wr_lctl & cfg_be[0] & cfg_wdata[5]
		& ~IS_UPSTREAM;

	assign fts_count = ext_sync_r ? `PLSR_FTS_LONG : `PLSR_FTS_SHORT;
	assign fts_send  = lp_exit;

	//------------------------------------------------------------
	// link status
	//------------------------------------------------------------
	logic [3:0] cur_speed_r;
	logic       train_err_r;
	logic       training_r;
	logic       dl_active_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cur_speed_r <= `PLSR_RST_CUR_SPEED;
		end else if (phy_in_l0) begin
			cur_speed_r <= phy_speed_5g ? 4'h2 : 4'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			train_err_r <= 1'b0;
		end else if (phy_train_fail) begin
			train_err_r <= 1'b1;
		end else if (phy_in_l0) begin
			train_err_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			training_r  <= 1'b0;
			dl_active_r <= 1'b0;
		end else begin
			training_r  <= phy_training;
			dl_active_r <= dl_active;
		end
	end

	logic [15:0] lsts_word;
	always_comb begin
		lsts_word        = 16'h0000;
		lsts_word[3:0]   = cur_speed_r;
		lsts_word[9:4]   = `PLSR_RST_NEG_WIDTH;
		lsts_word[10]    = train_err_r;
		lsts_word[11]    = training_r;
		lsts_word[12]    = slot_clk_r;
		lsts_word[13]    = dl_active_r;
	end

	//------------------------------------------------------------
	// slot capabilities: power limit value and scale
	//------------------------------------------------------------
	logic pwr_lim_wr;
	assign pwr_lim_wr = wr_scap & ~IS_UPSTREAM & (|cfg_be[2:0]);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			slot_pwr_value <= 8'h00;
			slot_pwr_scale <= 2'h0;
		end else if (pwr_lim_wr) begin
			if (cfg_be[0])
				slot_pwr_value[0] <= cfg_wdata[7];
			if (cfg_be[1])
				slot_pwr_value[7:1] <= cfg_wdata[14:8];
			if (cfg_be[1])
				slot_pwr_scale[0] <= cfg_wdata[15];
			if (cfg_be[2])
				slot_pwr_scale[1] <= cfg_wdata[16];
		end
	end

	//------------------------------------------------------------
	// slot control
	//------------------------------------------------------------
	logic [4:0] hp_en_r;  // button, fault, -, presence, cmd done
	logic       hp_master_r;
	logic       dl_chg_en_r;
	logic       sctl_wr;
	logic       attn_wr, pwr_wr;

	assign sctl_wr = wr_sctl & ~IS_UPSTREAM;

	function automatic logic [1:0] ind_next(input logic [1:0] cur,
		input logic [1:0] req);
		ind_next = (req == `PLSR_IND_RSVD) ? cur : req;
	endfunction : ind_next

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hp_en_r        <= 5'h00;
			hp_master_r    <= 1'b0;
			attn_ind       <= `PLSR_RST_IND;
			pwr_ind        <= `PLSR_RST_IND;
			slot_power_off <= 1'b0;
			dl_chg_en_r    <= 1'b0;
		end else if (sctl_wr) begin
			if (cfg_be[0]) begin
				hp_en_r     <= {cfg_wdata[4:3], 1'b0, cfg_wdata[1:0]};
				hp_master_r <= cfg_wdata[5];
				attn_ind    <= ind_next(attn_ind, cfg_wdata[7:6]);
			end
			if (cfg_be[1]) begin
				pwr_ind        <= ind_next(pwr_ind, cfg_wdata[9:8]);
				slot_power_off <= cfg_wdata[10];
				dl_chg_en_r    <= cfg_wdata[12];
			end
		end
	end

	assign attn_wr = sctl_wr & cfg_be[0];
	assign pwr_wr  = sctl_wr & cfg_be[1];

	//------------------------------------------------------------
	// slot status: link-active change flag, write one to clear
	//------------------------------------------------------------
	logic dl_prev_r;
	logic dl_clr;
	assign dl_clr = sctl_wr & cfg_be[3] & cfg_wdata[24];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dl_prev_r  <= 1'b0;
			dl_changed <= 1'b0;
		end else begin
			dl_prev_r <= dl_active_r;
			// a change in the clearing cycle wins over the clear
			if (dl_active_r != dl_prev_r)
				dl_changed <= 1'b1;
			else if (dl_clr)
				dl_changed <= 1'b0;
		end
	end

	// hot-plug interrupt, combinational from the stored enables, dl_changed and the live event inputs
	assign hp_irq = hp_master_r & ~IS_UPSTREAM & (
		(hp_en_r[0] & hp_button) | (hp_en_r[1] & hp_pwr_fault) |
		(hp_en_r[3] & hp_presence) | (hp_en_r[4] & hp_cmd_done) |
		(dl_chg_en_r & dl_changed));

	//------------------------------------------------------------
	// message requests
	//------------------------------------------------------------
	// one pulse per write; power limit takes priority when one
	// access could trigger both (offsets differ, so it cannot)
	always_comb begin
		msg_kind = plsr_pkg::PLSR_MSG_NONE;
		if (pwr_lim_wr)
			msg_kind = plsr_pkg::PLSR_MSG_POWER_LIMIT;
		else if (attn_wr)
			msg_kind = plsr_pkg::PLSR_MSG_ATTN_IND;
		else if (pwr_wr)
			msg_kind = plsr_pkg::PLSR_MSG_PWR_IND;
	end
	assign msg_valid = (msg_kind != plsr_pkg::PLSR_MSG_NONE);

	//------------------------------------------------------------
	// read data
	//------------------------------------------------------------
	logic [31:0] scap_word, sctl_word;
	always_comb begin
		scap_word       = 32'h0000_0000;
		scap_word[14:7] = slot_pwr_value;
		scap_word[16:15] = slot_pwr_scale;
		sctl_word       = 32'h0000_0000;
		sctl_word[5:0]  = {hp_master_r, hp_en_r};
		sctl_word[7:6]  = attn_ind;
		sctl_word[9:8]  = pwr_ind;
		sctl_word[10]   = slot_power_off;
		sctl_word[12]   = dl_chg_en_r;
		sctl_word[24]   = dl_changed;
		if (IS_UPSTREAM) begin
			scap_word = 32'h0000_0000;
			sctl_word = 32'h0000_0000;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_rdata <= 32'h0000_0000;
		end else if (cfg_rd) begin
			unique case (cfg_addr)
				`PLSR_OFS_LINK_CAP: cfg_rdata <= lcap_word;
				`PLSR_OFS_LINK_CTL: cfg_rdata <= {lsts_word, 8'h00,
					ext_sync_r, common_clock, 1'b0, link_disable,
					2'h0, active_state_power_mgmt};
				`PLSR_OFS_SLOT_CAP: cfg_rdata <= scap_word;
				`PLSR_OFS_SLOT_CTL: cfg_rdata <= sctl_word;
				default:            cfg_rdata <= 32'h0000_0000;
			endcase
		end
	end

	// lcap write is decoded only to be ignored
	logic unused_ok;
	assign unused_ok = wr_lcap;
endmodule : plsr_regs
`default_nettype wire

//--- rtl/plsr_defs.svh
// Purpose: offsets, training set counts and reset values of the port link/slot bank
// Assumes: 32-bit dword configuration access, byte enables per lane
// Notes:   definitions only
`ifndef PLSR_DEFS_SVH
`define PLSR_DEFS_SVH

`define PLSR_OFS_LINK_CAP   8'hCC
`define PLSR_OFS_LINK_CTL   8'hD0
`define PLSR_OFS_SLOT_CAP   8'hD4
`define PLSR_OFS_SLOT_CTL   8'hD8

`define PLSR_RST_MAX_SPEED  4'h2
`define PLSR_RST_MAX_WIDTH  6'h01
`define PLSR_RST_ACTIVE_STATE_POWER_MGMT_SUP   2'h0
`define PLSR_RST_L0S_LAT    3'h3
`define PLSR_RST_L1_LAT     3'h0
`define PLSR_RST_CUR_SPEED  4'h2
`define PLSR_RST_NEG_WIDTH  6'h01
`define PLSR_RST_IND        2'h3
`define PLSR_IND_RSVD       2'h0

`define PLSR_FTS_LONG       13'h1000
`define PLSR_FTS_SHORT      13'h0080

`endif

//--- rtl/plsr_pkg.sv
// Purpose: shared types of the port link/slot bank
// Assumes: nothing
// Notes:   message kinds raised toward the link partner
package plsr_pkg;
	typedef enum logic [1:0] {
		PLSR_MSG_NONE,
		PLSR_MSG_POWER_LIMIT,
		PLSR_MSG_ATTN_IND,
		PLSR_MSG_PWR_IND
	} plsr_msg_t;
endpackage : plsr_pkg

//--- rtl/plsr_sync.sv
// Purpose: two-flop synchroniser for pin-level inputs
// Assumes: inputs are quasi-static levels
// Notes:   first stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module plsr_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// level in and out
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule : plsr_sync
`default_nettype wire

//--- dv/plsr_link_model.sv
// Purpose: far-end link model that answers retrain requests
// Assumes: same core clock as the register bank
// Notes:   link layer comes up only at the end of a training run
`timescale 1ns/10ps
`default_nettype none
module plsr_link_model #(
	parameter int TRAIN_CYC = 10
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// requests from the bank
	input  wire logic retrain_pulse,
	input  wire logic link_disable,
	// link state back to the bank
	output var  logic phy_training,
	output var  logic phy_in_l0,
	output var  logic dl_active
);
	int cnt_r;

	// a disabled link drops everything, even in mid-training
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r        <= 0;
			phy_training <= 1'b0;
			phy_in_l0    <= 1'b0;
			dl_active    <= 1'b0;
		end else if (link_disable) begin
			cnt_r        <= 0;
			phy_training <= 1'b0;
			phy_in_l0    <= 1'b0;
			dl_active    <= 1'b0;
		end else if (retrain_pulse) begin
			cnt_r        <= TRAIN_CYC;
			phy_training <= 1'b1;
			phy_in_l0    <= 1'b0;
		end else if (cnt_r != 0) begin
			cnt_r <= cnt_r - 1;
			if (cnt_r == 1) begin
				phy_training <= 1'b0;
				phy_in_l0    <= 1'b1;
				dl_active    <= 1'b1;
			end
		end
	end
endmodule : plsr_link_model
`default_nettype wire

//--- dv/plsr_regs_asserts.sv
// Purpose: port-level checks of the link/slot register bank
// Assumes: one core clock, async low reset
// Notes:   slot control write checks use single-lane writes so one message is due; the power limit check writes all four lanes
`timescale 1ns/10ps
`default_nettype none
`include "plsr_defs.svh"
module plsr_regs_asserts #(
	parameter bit IS_UPSTREAM = 1'b1
) (
	// clock and reset
	input wire logic                clk,
	input wire logic                rst_n,
	// access and status inputs
	input wire logic                cfg_wr,
	input wire logic [7:0]          cfg_addr,
	input wire logic [3:0]          cfg_be,
	input wire logic [31:0]         cfg_wdata,
	input wire logic                dl_active,
	input wire logic                lp_exit,
	input wire logic                hp_button,
	input wire logic                hp_pwr_fault,
	input wire logic                hp_presence,
	input wire logic                hp_cmd_done,
	// outputs under check
	input wire logic [1:0]          active_state_power_mgmt,
	input wire logic                link_disable,
	input wire logic                retrain_pulse,
	input wire logic [12:0]         fts_count,
	input wire logic                fts_send,
	input wire logic [1:0]          attn_ind,
	input wire logic [1:0]          pwr_ind,
	input wire logic                slot_power_off,
	input wire logic [7:0]          slot_pwr_value,
	input wire logic [1:0]          slot_pwr_scale,
	input wire plsr_pkg::plsr_msg_t msg_kind,
	input wire logic                msg_valid,
	input wire logic                hp_irq,
	input wire logic                dl_changed
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	logic ds_wr;
	assign ds_wr = cfg_wr && !IS_UPSTREAM;

	property p_fts; fts_count == 13'h1000 || fts_count == 13'h0080; endproperty
	a_fts: assert property (p_fts) else $error("fts count off");
	property p_fts_send; fts_send == lp_exit; endproperty
	a_fts_send: assert property (p_fts_send) else $error("fts send");
	property p_retrain;
		retrain_pulse == (ds_wr && cfg_addr == `PLSR_OFS_LINK_CTL
			&& cfg_be[0] && cfg_wdata[5]);
	endproperty
	a_retrain: assert property (p_retrain) else $error("retrain");
	property p_attn;
		(ds_wr && cfg_addr == `PLSR_OFS_SLOT_CTL && cfg_be == 4'h1
			&& cfg_wdata[7:6] != 2'h0)
		|-> msg_valid && msg_kind == plsr_pkg::PLSR_MSG_ATTN_IND
		##1 attn_ind == $past(cfg_wdata[7:6]);
	endproperty
	a_attn: assert property (p_attn) else $error("attention write");
	property p_pwr;
		(ds_wr && cfg_addr == `PLSR_OFS_SLOT_CTL && cfg_be == 4'h2
			&& cfg_wdata[9:8] != 2'h0)
		|-> msg_valid && msg_kind == plsr_pkg::PLSR_MSG_PWR_IND
		##1 pwr_ind == $past(cfg_wdata[9:8])
		&& slot_power_off == $past(cfg_wdata[10]);
	endproperty
	a_pwr: assert property (p_pwr) else $error("power write");
	property p_lim;
		(ds_wr && cfg_addr == `PLSR_OFS_SLOT_CAP && cfg_be == 4'hF)
		|-> msg_valid && msg_kind == plsr_pkg::PLSR_MSG_POWER_LIMIT
		##1 slot_pwr_value == $past(cfg_wdata[14:7])
		&& slot_pwr_scale == $past(cfg_wdata[16:15]);
	endproperty
	a_lim: assert property (p_lim) else $error("power limit write");
	property p_ind; attn_ind != 2'h0 && pwr_ind != 2'h0; endproperty
	a_ind: assert property (p_ind) else $error("indicator code");
	property p_pm; active_state_power_mgmt != 2'h2; endproperty
	a_pm: assert property (p_pm) else $error("power mgmt code");
	property p_up; IS_UPSTREAM |-> !link_disable; endproperty
	a_up: assert property (p_up) else $error("upstream disable");
	property p_msg; msg_valid |-> cfg_wr; endproperty
	a_msg: assert property (p_msg) else $error("stray message");
	property p_irq;
		hp_irq |-> hp_button || hp_pwr_fault || hp_presence || hp_cmd_done
			|| dl_changed;
	endproperty
	a_irq: assert property (p_irq) else $error("stray interrupt");
	property p_dlchg;
		(!IS_UPSTREAM && $changed(dl_active)) |-> ##[1:3] dl_changed;
	endproperty
	a_dlchg: assert property (p_dlchg) else $error("no change flag");

	c_retrain: cover property (retrain_pulse);
	c_attn: cover property (msg_valid && msg_kind == plsr_pkg::PLSR_MSG_ATTN_IND);
	c_irq: cover property (hp_irq);
endmodule : plsr_regs_asserts

bind plsr_regs plsr_regs_asserts #(.IS_UPSTREAM(IS_UPSTREAM)) plsr_regs_asserts_inst (
	.clk(clk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
	.cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .dl_active(dl_active),
	.lp_exit(lp_exit), .hp_button(hp_button), .hp_pwr_fault(hp_pwr_fault),
	.hp_presence(hp_presence), .hp_cmd_done(hp_cmd_done),
	.active_state_power_mgmt(active_state_power_mgmt),
	.link_disable(link_disable), .retrain_pulse(retrain_pulse),
	.fts_count(fts_count), .fts_send(fts_send), .attn_ind(attn_ind),
	.pwr_ind(pwr_ind), .slot_power_off(slot_power_off),
	.slot_pwr_value(slot_pwr_value), .slot_pwr_scale(slot_pwr_scale),
	.msg_kind(msg_kind), .msg_valid(msg_valid), .hp_irq(hp_irq),
	.dl_changed(dl_changed));
`default_nettype wire

//--- dv/tb.sv
// Purpose: self-checking bench of a downstream port register bank
// Assumes: hot-plug and slot clock straps tied high
// Notes:   status reads are polled because their latency is not fixed
`timescale 1ns/10ps
`default_nettype none
`include "plsr_defs.svh"
module tb;
	logic clk = 1'b0, rst_n = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0;
	logic [7:0] cfg_addr = 8'h00, ld_port = 8'h00;
	logic [3:0] cfg_be = 4'h0, ld_speed = 4'h0;
	logic [31:0] cfg_wdata = 32'h0, cfg_rdata;
	logic ld_valid = 1'b0, fail = 1'b0, spd5 = 1'b1, lp_exit = 1'b0;
	logic hp_button = 1'b0, s_msg, s_rt;
	logic [2:0] hp_ev = 3'h0;
	logic [1:0] ld_pm = 2'h0, pm, attn_ind, pwr_ind, pwr_scale;
	logic [2:0] ld_l0s = 3'h0, ld_l1 = 3'h0;
	logic link_disable, retrain_pulse, common_clock, fts_send, pwr_off;
	logic msg_valid, hp_irq, dl_changed, training, in_l0, dl_active;
	logic [12:0] fts_count;
	logic [7:0] pwr_value;
	plsr_pkg::plsr_msg_t msg_kind, s_kind;
	int errors = 0, checks = 0;

	always #12.5 clk = ~clk;

	plsr_regs #(.PORT_INDEX(8'h02), .IS_UPSTREAM(1'b0)) plsr_regs_inst (
		.clk(clk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
		.cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
		.cfg_rdata(cfg_rdata), .ld_valid(ld_valid), .ld_max_speed(ld_speed),
		.ld_active_state_power_mgmt(ld_pm), .ld_l0s_lat(ld_l0s),
		.ld_l1_lat(ld_l1), .ld_port_num(ld_port), .slot_clock_strap(1'b1),
		.hot_plug_strap(1'b1), .phy_training(training),
		.phy_train_fail(fail), .phy_in_l0(in_l0), .phy_speed_5g(spd5),
		.dl_active(dl_active), .lp_exit(lp_exit), .hp_button(hp_button),
		.hp_pwr_fault(hp_ev[0]), .hp_presence(hp_ev[1]),
		.hp_cmd_done(hp_ev[2]),
		.active_state_power_mgmt(pm), .link_disable(link_disable),
		.retrain_pulse(retrain_pulse), .common_clock(common_clock),
		.fts_count(fts_count), .fts_send(fts_send), .attn_ind(attn_ind),
		.pwr_ind(pwr_ind), .slot_power_off(pwr_off),
		.slot_pwr_value(pwr_value), .slot_pwr_scale(pwr_scale),
		.msg_kind(msg_kind), .msg_valid(msg_valid), .hp_irq(hp_irq),
		.dl_changed(dl_changed));

	plsr_link_model #(.TRAIN_CYC(10)) plsr_link_model_inst (
		.clk(clk), .rst_n(rst_n), .retrain_pulse(retrain_pulse),
		.link_disable(link_disable), .phy_training(training),
		.phy_in_l0(in_l0), .dl_active(dl_active));

	// ----------------------------------------------------------------
	// access and compare helpers, entered 1 ns after a rising edge
	// ----------------------------------------------------------------
	task automatic wrap_up;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : wrap_up

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// message and retrain pulses stand only in the write cycle
	task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
		cfg_wr = 1'b1;
		cfg_addr = a;
		cfg_be = b;
		cfg_wdata = d;
		#5;
		s_msg = msg_valid;
		s_kind = msg_kind;
		s_rt = retrain_pulse;
		@(posedge clk);
		#1;
		cfg_wr = 1'b0;
		@(posedge clk);
		#1;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		cfg_rd = 1'b1;
		cfg_addr = a;
		@(posedge clk);
		#1;
		cfg_rd = 1'b0;
		d = cfg_rdata;
		@(posedge clk);
		#1;
	endtask : rd

	task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
			input string nm);
		logic [31:0] d;
		for (int i = 0; i < 20; i++) begin
			rd(a, d);
			if ((d & m) === e)
				break;
		end
		chk(nm, e, d & m);
		if ((d & m) !== e)
			wrap_up();
	endtask : poll

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		logic [31:0] d;
		rd(`PLSR_OFS_LINK_CAP, d);
		chk("link_cap", 32'h02303012, d);
		rd(`PLSR_OFS_LINK_CTL, d);
		chk("link_ctl", 32'h10120000, d);
		rd(`PLSR_OFS_SLOT_CAP, d);
		chk("slot_cap", 32'h0, d);
		rd(`PLSR_OFS_SLOT_CTL, d);
		chk("slot_ctl", 32'h000003C0, d);
		rd(8'hE0, d);
		chk("unmapped", 32'h0, d);
		chk("fts_count", 32'h80, fts_count);
		wr(`PLSR_OFS_LINK_CAP, 4'hF, 32'hFFFFFFFF);
		rd(`PLSR_OFS_LINK_CAP, d);
		chk("cap_ro", 32'h02303012, d);
		ld_speed = 4'h1;
		ld_pm = 2'h3;
		ld_l0s = 3'h5;
		ld_l1 = 3'h6;
		ld_port = 8'h3A;
		ld_valid = 1'b1;
		@(posedge clk);
		#1;
		ld_valid = 1'b0;
		rd(`PLSR_OFS_LINK_CAP, d);
		chk("cap_load", 32'h3A335C11, d);
		$display("test reset and load done");
	endtask : t_reset

	task automatic t_link;
		logic [31:0] d;
		wr(`PLSR_OFS_LINK_CTL, 4'h1, 32'hD3);
		rd(`PLSR_OFS_LINK_CTL, d);
		chk("ctl_rd", 32'hD3, d & 32'hFFFF);
		chk("ctl_out", 32'hF, {pm, link_disable, common_clock});
		chk("fts_long", 32'h1000, fts_count);
		lp_exit = 1'b1;
		#2;
		chk("fts_send", 32'h1, fts_send);
		@(posedge clk);
		#1;
		lp_exit = 1'b0;
		wr(`PLSR_OFS_LINK_CTL, 4'h1, 32'h02);
		rd(`PLSR_OFS_LINK_CTL, d);
		chk("pm_bad", 32'h0, d & 32'hFFFF);
		wr(`PLSR_OFS_LINK_CTL, 4'h1, 32'h01);
		chk("pm_one", 32'h1, pm);
		$display("test link control done");
	endtask : t_link

	task automatic t_train;
		fail = 1'b1;
		@(posedge clk);
		#1;
		fail = 1'b0;
		poll(`PLSR_OFS_LINK_CTL, 32'h04000000, 32'h04000000, "train_err");
		wr(`PLSR_OFS_LINK_CTL, 4'h1, 32'h20);
		chk("retrain", 32'h1, s_rt);
		poll(`PLSR_OFS_LINK_CTL, 32'h08000020, 32'h08000000, "training");
		poll(`PLSR_OFS_LINK_CTL, 32'h2C000000, 32'h20000000, "link_up");
		spd5 = 1'b0;
		poll(`PLSR_OFS_LINK_CTL, 32'h000F0000, 32'h00010000, "speed");
		spd5 = 1'b1;
		poll(`PLSR_OFS_SLOT_CTL, 32'h01000000, 32'h01000000, "dl_chg");
		wr(`PLSR_OFS_SLOT_CTL, 4'h8, 32'h01000000);
		poll(`PLSR_OFS_SLOT_CTL, 32'h01000000, 32'h0, "dl_clr");
		chk("dl_changed", 32'h0, dl_changed);
		$display("test training done");
	endtask : t_train

	task automatic t_slot;
		logic [31:0] d;
		wr(`PLSR_OFS_SLOT_CAP, 4'hF, 32'hFFF92D7F);
		chk("lim_msg", {1'b1, plsr_pkg::PLSR_MSG_POWER_LIMIT}, {s_msg, s_kind});
		chk("lim_out", {8'h5A, 2'h2}, {pwr_value, pwr_scale});
		rd(`PLSR_OFS_SLOT_CAP, d);
		chk("slot_cap", 32'h00012D00, d);
		wr(`PLSR_OFS_SLOT_CTL, 4'h1, 32'h40);
		chk("attn_msg", {1'b1, plsr_pkg::PLSR_MSG_ATTN_IND}, {s_msg, s_kind});
		wr(`PLSR_OFS_SLOT_CTL, 4'h1, 32'h00);
		chk("attn_keep", 32'h1, attn_ind);
		wr(`PLSR_OFS_SLOT_CTL, 4'h2, 32'h0600);
		chk("pwr_msg", {1'b1, plsr_pkg::PLSR_MSG_PWR_IND}, {s_msg, s_kind});
		chk("pwr_out", {2'h2, 1'b1}, {pwr_ind, pwr_off});
		rd(`PLSR_OFS_SLOT_CTL, d);
		chk("slot_ctl", 32'h0640, d);
		hp_button = 1'b1;
		wr(`PLSR_OFS_SLOT_CTL, 4'h1, 32'h41);
		chk("irq_nomaster", 32'h0, hp_irq);
		wr(`PLSR_OFS_SLOT_CTL, 4'h1, 32'h61);
		chk("irq_on", 32'h1, hp_irq);
		hp_ev = 3'h7;
		wr(`PLSR_OFS_SLOT_CTL, 4'h1, 32'h60);
		chk("irq_noevent", 32'h0, hp_irq);
		wr(`PLSR_OFS_SLOT_CTL, 4'h1, 32'h7A);
		chk("irq_other", 32'h1, hp_irq);
		hp_button = 1'b0;
		hp_ev = 3'h0;
		$display("test slot done");
	endtask : t_slot

	initial begin
		repeat (4) @(posedge clk);
		#1;
		rst_n = 1'b1;
		repeat (8) @(posedge clk);
		#1;
		t_reset();
		t_link();
		t_train();
		t_slot();
		wrap_up();
	end
endmodule : tb
`default_nettype wire
